/* File: src/asc_map.svh */
// Purpose: timing constants for the byte-wide static memory host controller
// Assumes: 20 MHz clock, 50 ns period
// Notes:   times in ns, cycle counts derived from the clock period
//
// Notes on behaviour
// [RQ1] chip select high means standby, data floats
// [RQ2] select plus output enable reads the byte
// [RQ3] write strobe disables memory drivers always
// [RQ4] write happens only while select and strobe overlap
// [RQ5] setup and hold measured from write end
// [RQ6] address stable before write begins
// [RQ7] select and address valid before write end
// [RQ8] data valid before and after write end
// [RQ9] address held 10ns after write end
// [RQ10] no write drive until read data floats
// [RQ11] back-to-back cycles at 85ns, no precharge
// [RQ12] output enable only for reads, strobe otherwise high
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
`define ASC_CLK_PERIOD_NS    50
`define ASC_CYCLE_TIME_NS    85
`define ASC_WR_RECOVERY_NS   10
`define ASC_FLOAT_NS         30
// least times round up to whole cycles; zero stays zero
`define ASC_CEIL_CYC(t)      (((t) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_CYCLE_CYC        `ASC_CEIL_CYC(`ASC_CYCLE_TIME_NS)
`define ASC_RECOVERY_CYC     `ASC_CEIL_CYC(`ASC_WR_RECOVERY_NS)
`define ASC_FLOAT_CYC        `ASC_CEIL_CYC(`ASC_FLOAT_NS)
`define ASC_ADDR_W           15
`define ASC_DATA_W           8
`endif

/* File: src/asc_pkg.sv */
// Purpose: types for the static memory host controller
// Assumes: constants come from asc_map.svh
// Notes:   states plus address and data types
`include "asc_map.svh"
package asc_pkg;
  typedef logic [`ASC_ADDR_W-1:0] asc_addr_t;
  typedef logic [`ASC_DATA_W-1:0] asc_data_t;
  typedef enum logic [2:0] {
    ASC_IDLE  = 3'b000,
    ASC_SETUP = 3'b001,
    ASC_PULSE = 3'b010,
    ASC_HOLD  = 3'b011,
    ASC_FLOAT = 3'b100
  } asc_state_t;
endpackage : asc_pkg

/* File: src/asc_timer.sv */
// Purpose: down counter for phase lengths
// Assumes: load has priority over counting
// Notes:   done is high while count is zero
`timescale 1ns/10ps
`include "asc_map.svh"
module asc_timer (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // control
  input  wire logic       load_i,
  input  wire logic [3:0] count_i,
  output logic            done_o
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) cnt_reg <= 4'h0;
    else if (load_i) cnt_reg <= count_i;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  assign done_o = (cnt_reg == 4'h0);
endmodule : asc_timer

/* File: src/asc_host.sv */
// Purpose: host that reads and writes a 32K by 8 asynchronous static memory
// Assumes: memory pins sampled synchronously, one clock domain
// Notes:   one request at a time; busy_o high while a cycle runs
`timescale 1ns/10ps
`include "asc_map.svh"
module asc_host
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      nrst_i,
  // user request
  input  wire logic      req_i,
  input  wire logic      we_i,
  input  asc_pkg::asc_addr_t addr_i,
  input  asc_pkg::asc_data_t wdata_i,
  output logic           busy_o,
  output logic           rvalid_o,
  output asc_pkg::asc_data_t rdata_o,
  // memory pins
  output asc_pkg::asc_addr_t mem_addr_o,
  output logic           mem_cs_n_o,
  output logic           mem_oe_n_o,
  output logic           mem_we_n_o,
  input  asc_pkg::asc_data_t mem_dq_i,
  output asc_pkg::asc_data_t mem_dq_o,
  output logic           mem_dq_oe_o
);
  import asc_pkg::*;

  // ****************************************
  // state and phase timer
  // ****************************************
  asc_state_t state_reg, state_next;
  logic       wr_reg;
  logic       read_used_reg;
  logic       tmr_load;
  logic [3:0] tmr_count;
  logic       tmr_done;

  asc_timer u_timer (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  wire take     = (state_reg == ASC_IDLE) && req_i;
  // a write after a read first waits for the memory drivers to float
  wire need_flt = take && we_i && read_used_reg; // RQ10
  wire flt_end  = (state_reg == ASC_FLOAT) && tmr_done;
  wire go_setup = (take && !need_flt) || flt_end;
  // direction counts from the take edge, so data leads the strobe by a cycle
  wire dir_wr   = take ? we_i : wr_reg;
  // pulse covers full cycle time so back-to-back works at 85ns
  wire pls_end  = (state_reg == ASC_PULSE) && tmr_done; // RQ11

  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_count  = 4'h0;
    case (state_reg)
      ASC_IDLE: begin
        if (need_flt) begin
          state_next = ASC_FLOAT;
          tmr_load   = 1'b1;
          tmr_count  = 4'(`ASC_FLOAT_CYC - 1);
        end else if (take) begin
          state_next = ASC_SETUP;
        end
      end
      ASC_FLOAT: if (tmr_done) state_next = ASC_SETUP;
      // one full cycle of address before select and strobe go low
      ASC_SETUP: begin
        state_next = ASC_PULSE; // RQ6
        tmr_load   = 1'b1;
        tmr_count  = 4'(`ASC_CYCLE_CYC - 1);
      end
      ASC_PULSE: begin
        if (tmr_done) begin
          state_next = wr_reg ? ASC_HOLD : ASC_IDLE;
          tmr_load   = wr_reg;
          tmr_count  = 4'(`ASC_RECOVERY_CYC - 1);
        end
      end
      ASC_HOLD: if (tmr_done) state_next = ASC_IDLE;
      default: state_next = ASC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) state_reg <= ASC_IDLE;
    else state_reg <= state_next;
  end

  // ****************************************
  // request capture and pins
  // ****************************************
  // address, data and direction latched once; stable through hold phase
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_reg     <= 1'b0;
      mem_addr_o <= 15'h0000;
      mem_dq_o   <= 8'h00;
    end else if (take) begin
      wr_reg     <= we_i;
      mem_addr_o <= addr_i; // RQ7 RQ9
      mem_dq_o   <= wdata_i; // RQ8
    end
  end

  wire in_pulse = (state_next == ASC_PULSE);
  // data driven from setup through hold, covering setup and hold of data
  wire drv_data = dir_wr && (state_next == ASC_SETUP || state_next == ASC_PULSE
                  || state_next == ASC_HOLD);
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mem_cs_n_o  <= 1'b1; // RQ1
      mem_oe_n_o  <= 1'b1;
      mem_we_n_o  <= 1'b1;
      mem_dq_oe_o <= 1'b0;
    end else begin
      // select and strobe fall and rise together, so write end is one edge
      mem_cs_n_o  <= !in_pulse; // RQ4 RQ5
      mem_we_n_o  <= !(in_pulse && wr_reg); // RQ3
      mem_oe_n_o  <= !(in_pulse && !wr_reg); // RQ2 RQ12
      mem_dq_oe_o <= drv_data; // RQ8
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      read_used_reg <= 1'b0;
      busy_o        <= 1'b0;
      rvalid_o      <= 1'b0;
      rdata_o       <= 8'h00;
    end else begin
      busy_o   <= (state_next != ASC_IDLE);
      rvalid_o <= pls_end && !wr_reg;
      if (pls_end && !wr_reg) rdata_o <= mem_dq_i;
      if (pls_end) read_used_reg <= !wr_reg;
      else if (flt_end) read_used_reg <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_no_contention;
    @(posedge clk_i) disable iff (!nrst_i) !(mem_dq_oe_o && !mem_oe_n_o);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("host drives on read"); // RQ12

  property p_we_with_cs;
    @(posedge clk_i) disable iff (!nrst_i) !mem_we_n_o |-> !mem_cs_n_o && mem_oe_n_o;
  endproperty
  a_we_with_cs: assert property (p_we_with_cs) else $error("strobe without select"); // RQ4

  property p_pulse_len;
    @(posedge clk_i) disable iff (!nrst_i) $fell(mem_cs_n_o) |-> !mem_cs_n_o [*2];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("select pulse short"); // RQ11

  property p_addr_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(mem_we_n_o) |-> $stable(mem_addr_o) && mem_dq_oe_o;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved at write end"); // RQ9

  property p_addr_stable;
    @(posedge clk_i) disable iff (!nrst_i)
      !mem_cs_n_o && $past(!mem_cs_n_o) |-> $stable(mem_addr_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address changed in pulse"); // RQ7

  property p_setup;
    @(posedge clk_i) disable iff (!nrst_i) $fell(mem_cs_n_o) |-> $stable(mem_addr_o);
  endproperty
  a_setup: assert property (p_setup) else $error("address not set up"); // RQ6

  property p_data_setup;
    @(posedge clk_i) disable iff (!nrst_i) $fell(mem_we_n_o) |-> $past(mem_dq_oe_o);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("data not set up"); // RQ8

  property p_float;
    @(posedge clk_i) disable iff (!nrst_i) $rose(mem_oe_n_o) |-> !mem_dq_oe_o [*2];
  endproperty
  a_float: assert property (p_float) else $error("drive before float"); // RQ10

  property p_idle;
    @(posedge clk_i) disable iff (!nrst_i) !busy_o |-> mem_cs_n_o;
  endproperty
  a_idle: assert property (p_idle) else $error("selected while idle"); // RQ1
endmodule : asc_host

/* File: sim/asc_sram_model.sv */
// Purpose: behavioural 32K by 8 static memory
// Assumes: no clock, active-low controls
// Notes:   released data shows the inverse of the last byte
`timescale 1ns/10ps
module asc_sram_model
  import asc_pkg::*;
#(
  parameter int FLOAT_NS = 30
)
(
  // memory pins
  input  wire asc_pkg::asc_addr_t addr_i,
  input  wire logic               cs_n_i,
  input  wire logic               oe_n_i,
  input  wire logic               we_n_i,
  input  wire asc_pkg::asc_data_t dq_i,
  output asc_pkg::asc_data_t      dq_o,
  output logic                    dq_oe_o
);
  asc_data_t mem [0:32767];
  asc_data_t last_q = 8'h00;
  wire       rd_on = !cs_n_i && !oe_n_i && we_n_i;
  wire       wr_on = !cs_n_i && !we_n_i;
  // slow release, so a hasty write turnaround collides
  assign #(FLOAT_NS) dq_oe_o = rd_on;
  assign dq_o = dq_oe_o ? mem[addr_i] : ~last_q;
  always @(negedge wr_on) mem[addr_i] = dq_i;
  always @(dq_o or dq_oe_o) if (dq_oe_o) last_q = dq_o;
endmodule : asc_sram_model

/* File: sim/testbench.sv */
// Purpose: self-checking bench for the static memory host
// Assumes: 20 MHz clock, partner floats 30 ns after release
// Notes:   idle, read/write table and turnaround scenarios
`timescale 1ns/10ps
module testbench;
  import asc_pkg::*;
  logic      clk_i = 0, nrst_i = 0, req_i = 0, we_i = 0;
  asc_addr_t addr_i = 15'h0000, m_addr, a_q;
  asc_data_t wdata_i = 8'h00, rdata_o, h_dq, m_dq;
  logic      busy_o, rvalid_o, cs_n, oe_n, we_n, h_oe, m_oe;
  logic      wr_q = 0, cs_q = 1;
  int        num_errors = 0, checks_done = 0;
  asc_host uut (.clk_i, .nrst_i, .req_i, .we_i, .addr_i, .wdata_i, .busy_o,
    .rvalid_o, .rdata_o, .mem_addr_o(m_addr), .mem_cs_n_o(cs_n), .mem_oe_n_o(oe_n),
    .mem_we_n_o(we_n), .mem_dq_i(m_dq), .mem_dq_o(h_dq), .mem_dq_oe_o(h_oe));
  asc_sram_model sram (.addr_i(m_addr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .dq_i(h_oe ? h_dq : ~h_dq), .dq_o(m_dq), .dq_oe_o(m_oe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string s);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask : check
  // one request; n_exp edges from take to done
  task automatic op(input logic w, input asc_addr_t a, input asc_data_t d, input int n_exp);
    int n;
    @(posedge clk_i);
    req_i <= 1;
    we_i <= w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((w ? busy_o : !rvalid_o) !== 1'b0 && n < 20);
    check(16'(n), 16'(n_exp), "edges to done");
    if (!w) check(rdata_o, d, "read byte");
  endtask : op
  // wire watch on the falling edge, where pins are settled
  always @(negedge clk_i) if (nrst_i) begin
    if (h_oe && m_oe) check(1, 0, "bus contention");
    if (!oe_n) check(we_n, 1, "output enable during write");
    if (wr_q && we_n) check(m_addr, a_q, "address hold");
    if (!cs_n && cs_q) check(m_addr, a_q, "address setup");
    wr_q <= !cs_n && !we_n;
    cs_q <= cs_n;
    a_q <= m_addr;
  end
  task automatic t_idle;
    @(negedge clk_i);
    check({cs_n, oe_n, we_n, h_oe, busy_o}, 5'b11100, "idle pins");
    $display("idle done");
  endtask : t_idle
  task automatic t_rw;
    asc_addr_t ad [4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
    asc_data_t dv [4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
    for (int i = 0; i < 4; i++) op(1, ad[i], dv[i], 5);
    for (int i = 0; i < 4; i++) op(0, ad[i], dv[i], 4);
    $display("read write done");
  endtask : t_rw
  task automatic t_turn;
    op(0, 15'h0000, 8'hA5, 4);
    op(1, 15'h0000, 8'h3C, 6);
    op(0, 15'h0000, 8'h3C, 4);
    op(1, 15'h7FFF, 8'hC3, 6);
    op(0, 15'h7FFF, 8'hC3, 4);
    $display("turnaround done");
  endtask : t_turn
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // about 85 cycles expected, cut off at 2000
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1;
    t_idle;
    t_rw;
    t_turn;
    finish_test;
  end
endmodule : testbench
